// ==== include/mie_pkg.sv ====
// Package for the instruction execution core: opcodes, widths, cycle counts, carriers
// What this block does
// - Add and add-with-carry set carry to 1 on an eight-bit overflow and clear it otherwise.
// - Subtract and subtract-with-borrow clear carry on a borrow and set it when there is none.
// - The immediate move to bank zero writes only system registers 0x80 to 0x87.
// - Multiply puts the product low byte in the accumulator, high byte in R, sets zero, two cycles.
// - Decimal adjust turns a binary sum into packed decimal and updates carry in one cycle.
// - Bit tests skip when the chosen bit is 0 for the clear form or 1 for the set form.
// - Jump and call load counter bits 13..0 from the address, 15..14 from the page bits, two cycles.
// - The first indirect call pushes the counter and loads it from H and L in two cycles.
// - The second indirect call pushes the counter and loads it from Y and Z in two cycles.
// - Interrupt return pops the counter and re-enables the global interrupt in two cycles.
// - Return-with-literal pops the counter and loads the literal into the accumulator, two cycles.
// - A memory write costs one extra cycle for general RAM and none for a system register.
// - A conditional skip costs one extra cycle when taken and none when not.
package mie_pkg;
   typedef enum logic [4:0] {
      MIE_OP_NOP = 5'h00, MIE_OP_ADD = 5'h01, MIE_OP_ADC = 5'h02, MIE_OP_SUB = 5'h03,
      MIE_OP_SBC = 5'h04, MIE_OP_AND = 5'h05, MIE_OP_OR = 5'h06, MIE_OP_XOR = 5'h07,
      MIE_OP_COM = 5'h08, MIE_OP_MUL = 5'h09, MIE_OP_DAA = 5'h0A, MIE_OP_CMPSKIP = 5'h0B,
      MIE_OP_INCACC = 5'h0C, MIE_OP_DECACC = 5'h0D, MIE_OP_INCMEM = 5'h0E,
      MIE_OP_DECMEM = 5'h0F, MIE_OP_BITCLR = 5'h10, MIE_OP_BITSET = 5'h11,
      MIE_OP_JUMP = 5'h12, MIE_OP_CALL = 5'h13, MIE_OP_CALL_VIA_HIGH_LOW_PAIR = 5'h14, MIE_OP_CALLIDX = 5'h15,
      MIE_OP_RET = 5'h16, MIE_OP_IRET = 5'h17, MIE_OP_RETLIT = 5'h18, MIE_OP_BZMOVI = 5'h19
   } mie_op_t;

   localparam logic [7:0] MIE_BZ_LO = 8'h80;
   localparam logic [7:0] MIE_BZ_HI = 8'h87;
   localparam logic [7:0] MIE_SYSREG_BASE = 8'h80;
   localparam int MIE_BIT_ADDR_W = 14;
   localparam logic [1:0] MIE_CYC_BASE = 2'h1;
   localparam logic [1:0] MIE_CYC_LONG = 2'h2;
   localparam logic [15:0] MIE_PC_RST = 16'h0000;
   localparam int MIE_STACK_DEPTH = 16;

   // One instruction request with its operands
   typedef struct packed {
      mie_op_t op;
      logic mem_dst;
      logic [7:0] addr;
      logic [7:0] mem_val;
      logic [7:0] imm;
      logic [2:0] bit_sel;
      logic [13:0] jaddr;
   } mie_instr_t;

   // Result of one instruction
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] r;
      logic carry;
      logic dcarry;
      logic zero;
      logic mem_we;
      logic [7:0] mem_addr;
      logic [7:0] mem_data;
      logic skip;
      logic [15:0] pc;
      logic gie;
      logic [1:0] cycles;
   } mie_result_t;
endpackage

// ==== logic/mie_core.sv ====
// Instruction execution core: one instruction per request, result and cycle cost registered
`timescale 1ns/1ps
module mie_core import mie_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic instr_valid,
   input mie_instr_t instr,
   input wire logic [1:0] rom_page_select_bits,
   input wire logic [7:0] reg_h,
   input wire logic [7:0] reg_l,
   input wire logic [7:0] reg_y,
   input wire logic [7:0] reg_z,
   output logic instr_ready,
   output logic done,
   output mie_result_t result
);
   typedef enum logic [0:0] {MIE_IDLE = 1'b0, MIE_BUSY = 1'b1} mie_state_t;

   mie_state_t state_r, state_nxt;
   logic [1:0] wait_r, wait_nxt;
   logic done_r, done_nxt;
   mie_result_t res_r, res_nxt;
   logic [15:0] stack_r [MIE_STACK_DEPTH];
   logic [15:0] stack_wd;
   logic push, pop;
   logic [3:0] sp_r, sp_nxt;

   function automatic logic is_sysreg(input logic [7:0] a);
      return a >= MIE_SYSREG_BASE;
   endfunction

   assign instr_ready = (state_r == MIE_IDLE);
   assign done = done_r;
   assign result = res_r;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [8:0] sum;
      logic [15:0] prod;
      logic [7:0] a;
      logic [7:0] m;
      logic [8:0] adj;
      logic [7:0] nv;
      logic wr;
      state_nxt = state_r;
      wait_nxt = wait_r;
      done_nxt = 1'b0;
      res_nxt = res_r;
      sp_nxt = sp_r;
      push = 1'b0;
      pop = 1'b0;
      stack_wd = res_r.pc;
      sum = 9'h000;
      prod = 16'h0000;
      adj = 9'h000;
      nv = 8'h00;
      wr = 1'b0;
      a = res_r.acc;
      m = instr.mem_val;
      res_nxt.mem_we = 1'b0;
      res_nxt.skip = 1'b0;
      if (state_r == MIE_BUSY) begin
         // Extra cycles hold the core busy
         if (wait_r == 2'h1) begin
            state_nxt = MIE_IDLE;
            done_nxt = 1'b1;
         end
         wait_nxt = wait_r - 2'h1;
      end else if (instr_valid) begin
         res_nxt.pc = res_r.pc + 16'h0001;
         res_nxt.cycles = MIE_CYC_BASE;
         unique case (instr.op)
            MIE_OP_ADD, MIE_OP_ADC: begin
               sum = {1'b0, a} + {1'b0, m} +
                  {8'h00, (instr.op == MIE_OP_ADC) & res_r.carry};
               res_nxt.carry = sum[8];
               res_nxt.dcarry = (a[3:0] + m[3:0] +
                  {3'h0, (instr.op == MIE_OP_ADC) & res_r.carry}) > 5'h0F;
               nv = sum[7:0];
               wr = 1'b1;
            end
            MIE_OP_SUB, MIE_OP_SBC, MIE_OP_CMPSKIP: begin
               sum = {1'b0, a} - {1'b0, m} -
                  {8'h00, (instr.op == MIE_OP_SBC) & ~res_r.carry};
               res_nxt.carry = ~sum[8];
               res_nxt.zero = (sum[7:0] == 8'h00);
               if (instr.op == MIE_OP_CMPSKIP) begin
                  res_nxt.skip = (a == m);
               end else begin
                  res_nxt.dcarry = ({1'b0, a[3:0]} >= ({1'b0, m[3:0]} +
                     {4'h0, (instr.op == MIE_OP_SBC) & ~res_r.carry}));
                  nv = sum[7:0];
                  wr = 1'b1;
               end
            end
            MIE_OP_AND, MIE_OP_OR, MIE_OP_XOR, MIE_OP_COM: begin
               unique case (instr.op)
                  MIE_OP_AND: nv = a & m;
                  MIE_OP_OR: nv = a | m;
                  MIE_OP_XOR: nv = a ^ m;
                  default: nv = ~m;
               endcase
               wr = 1'b1;
            end
            MIE_OP_MUL: begin
               // Low byte to acc, high to R
               prod = a * m;
               res_nxt.acc = prod[7:0];
               res_nxt.r = prod[15:8];
               res_nxt.zero = (prod[7:0] == 8'h00);
               res_nxt.cycles = MIE_CYC_LONG;
            end
            MIE_OP_DAA: begin
               adj = {1'b0, a};
               if (a[3:0] > 4'h9 || res_r.dcarry) begin
                  adj = adj + 9'h006;
               end
               if (adj[7:4] > 4'h9 || res_r.carry || adj[8]) begin
                  adj = adj + 9'h060;
               end
               res_nxt.acc = adj[7:0];
               res_nxt.carry = adj[8] | res_r.carry;
            end
            MIE_OP_INCACC, MIE_OP_DECACC: begin
               // Result to acc, skip on zero
               nv = (instr.op == MIE_OP_INCACC) ? m + 8'h01 : m - 8'h01;
               res_nxt.acc = nv;
               res_nxt.skip = (nv == 8'h00);
            end
            MIE_OP_INCMEM, MIE_OP_DECMEM: begin
               // Memory in place, skip on zero
               nv = (instr.op == MIE_OP_INCMEM) ? m + 8'h01 : m - 8'h01;
               res_nxt.mem_we = 1'b1;
               res_nxt.mem_addr = instr.addr;
               res_nxt.mem_data = nv;
               res_nxt.skip = (nv == 8'h00);
            end
            MIE_OP_BITCLR, MIE_OP_BITSET: begin
               res_nxt.skip = (m[instr.bit_sel] == (instr.op == MIE_OP_BITSET));
            end
            MIE_OP_BZMOVI: begin
               if (instr.addr >= MIE_BZ_LO && instr.addr <= MIE_BZ_HI) begin
                  res_nxt.mem_we = 1'b1;
                  res_nxt.mem_addr = instr.addr;
                  res_nxt.mem_data = instr.imm;
               end
            end
            MIE_OP_JUMP, MIE_OP_CALL: begin
               res_nxt.pc = {rom_page_select_bits, instr.jaddr};
               res_nxt.cycles = MIE_CYC_LONG;
               push = (instr.op == MIE_OP_CALL);
               stack_wd = res_r.pc + 16'h0001;
            end
            MIE_OP_CALL_VIA_HIGH_LOW_PAIR: begin
               res_nxt.pc = {reg_h, reg_l};
               res_nxt.cycles = MIE_CYC_LONG;
               push = 1'b1;
               stack_wd = res_r.pc + 16'h0001;
            end
            MIE_OP_CALLIDX: begin
               res_nxt.pc = {reg_y, reg_z};
               res_nxt.cycles = MIE_CYC_LONG;
               push = 1'b1;
               stack_wd = res_r.pc + 16'h0001;
            end
            MIE_OP_RET, MIE_OP_IRET, MIE_OP_RETLIT: begin
               // Pop, and interrupts back on for iret
               pop = 1'b1;
               res_nxt.pc = stack_r[sp_r - 4'h1];
               res_nxt.cycles = MIE_CYC_LONG;
               if (instr.op == MIE_OP_IRET) begin
                  res_nxt.gie = 1'b1;
               end
               if (instr.op == MIE_OP_RETLIT) begin
                  res_nxt.acc = instr.imm;
               end
            end
            default: begin
            end
         endcase
         if (wr) begin
            res_nxt.zero = (nv == 8'h00);
            if (instr.mem_dst) begin
               res_nxt.mem_we = 1'b1;
               res_nxt.mem_addr = instr.addr;
               res_nxt.mem_data = nv;
            end else begin
               res_nxt.acc = nv;
            end
         end
         // RAM write costs one more cycle
         if (res_nxt.mem_we && !is_sysreg(instr.addr) && instr.op != MIE_OP_BZMOVI) begin
            res_nxt.cycles = res_nxt.cycles + 2'h1;
         end
         // Taken skip costs one more cycle
         if (res_nxt.skip) begin
            res_nxt.cycles = res_nxt.cycles + 2'h1;
            res_nxt.pc = res_nxt.pc + 16'h0001;
         end
         if (push) begin
            sp_nxt = sp_r + 4'h1;
         end
         if (pop) begin
            sp_nxt = sp_r - 4'h1;
         end
         if (res_nxt.cycles == MIE_CYC_BASE) begin
            done_nxt = 1'b1;
         end else begin
            state_nxt = MIE_BUSY;
            wait_nxt = res_nxt.cycles - 2'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= MIE_IDLE;
         wait_r <= 2'h0;
         done_r <= 1'b0;
         res_r <= '0;
         res_r.pc <= MIE_PC_RST;
         sp_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         wait_r <= wait_nxt;
         done_r <= done_nxt;
         res_r <= res_nxt;
         sp_r <= sp_nxt;
      end
   end

   // Stack has no reset; overflow wraps like the real 16-level buffer
   always_ff @(posedge clk) begin
      if (push) begin
         stack_r[sp_r] <= stack_wd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Multiply takes two cycles
   mul_two_a: assert property (@(posedge clk) disable iff (rst)
      instr_ready && instr_valid && instr.op == MIE_OP_MUL |=> !done ##1 done)
      else $error("multiply not two cycles");
   add_carry_a: assert property (@(posedge clk) disable iff (rst)
      instr_ready && instr_valid && instr.op == MIE_OP_ADD
      |=> result.carry == ($past(result.acc) + $past(instr.mem_val) > 9'h0FF))
      else $error("add carry wrong");
   sub_carry_a: assert property (@(posedge clk) disable iff (rst)
      instr_ready && instr_valid && instr.op == MIE_OP_SUB
      |=> result.carry == ($past(result.acc) >= $past(instr.mem_val)))
      else $error("sub carry wrong");
   bzmove_range_a: assert property (@(posedge clk) disable iff (rst)
      instr_ready && instr_valid && instr.op == MIE_OP_BZMOVI &&
      (instr.addr < MIE_BZ_LO || instr.addr > MIE_BZ_HI)
      |=> !result.mem_we)
      else $error("bank zero move out of range");
   cmp_skip_a: assert property (@(posedge clk) disable iff (rst)
      instr_ready && instr_valid && instr.op == MIE_OP_CMPSKIP
      |=> result.skip == ($past(result.acc) == $past(instr.mem_val)) &&
      result.cycles == (result.skip ? 2'h2 : 2'h1))
      else $error("compare skip wrong");
   // Skip adds a cycle; skip stands only in the first cycle
   skip_cost_a: assert property (@(posedge clk) disable iff (rst)
      result.skip && !result.mem_we |-> result.cycles == 2'h2 ##1 done)
      else $error("skip cycle cost wrong");
   jump_pc_a: assert property (@(posedge clk) disable iff (rst)
      instr_ready && instr_valid && instr.op == MIE_OP_JUMP
      |=> result.pc == {$past(rom_page_select_bits), $past(instr.jaddr)})
      else $error("jump target wrong");
   call_via_high_low_pair_pc_a: assert property (@(posedge clk) disable iff (rst)
      instr_ready && instr_valid && instr.op == MIE_OP_CALL_VIA_HIGH_LOW_PAIR
      |=> result.pc == {$past(reg_h), $past(reg_l)})
      else $error("hl call target wrong");
   iret_gie_a: assert property (@(posedge clk) disable iff (rst)
      instr_ready && instr_valid && instr.op == MIE_OP_IRET |=> result.gie)
      else $error("iret gie not set");

   mul_seen_c: cover property (@(posedge clk) disable iff (rst)
      instr_ready && instr_valid && instr.op == MIE_OP_MUL);
   skip_taken_c: cover property (@(posedge clk) disable iff (rst) result.skip ##1 done);
   ram_write_c: cover property (@(posedge clk) disable iff (rst)
      result.mem_we && result.cycles == 2'h2);
   iret_seen_c: cover property (@(posedge clk) disable iff (rst)
      instr_ready && instr_valid && instr.op == MIE_OP_IRET);
endmodule

// ==== testbench/mie_core_test.sv ====
// Self-checking bench for the instruction execution core
`timescale 1ns/1ps
module mie_core_test import mie_pkg::*; ;
   logic clk, rst, instr_valid, instr_ready, done, sk, we;
   mie_instr_t instr;
   logic [1:0] pg;
   logic [7:0] rh, rl, ry, rz;
   logic [15:0] p;
   mie_result_t res, r;
   int n_mismatch, compares, cyc;

   mie_core u_mie_core (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
      .rom_page_select_bits(pg), .reg_h(rh), .reg_l(rl), .reg_y(ry), .reg_z(rz),
      .instr_ready(instr_ready), .done(done), .result(res));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic end_of_test();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // One instruction: skip and write strobes are gathered over every cycle
   task automatic ex(input mie_op_t o, input logic md, input logic [7:0] a,
         input logic [7:0] v, input logic [7:0] i, input logic [2:0] b = 3'h0,
         input logic [13:0] j = 14'h0000);
      int k;
      k = 0;
      // One idle edge keeps valid low between two requests
      @(posedge clk);
      #1;
      while (instr_ready !== 1'b1 && k < 20) begin
         @(posedge clk);
         #1;
         k++;
      end
      instr = '{op: o, mem_dst: md, addr: a, mem_val: v, imm: i, bit_sel: b, jaddr: j};
      instr_valid = 1'b1;
      @(posedge clk);
      #1;
      instr_valid = 1'b0;
      cyc = 1;
      sk = res.skip;
      we = res.mem_we;
      while (done !== 1'b1 && cyc < 8) begin
         @(posedge clk);
         #1;
         cyc++;
         sk = sk | res.skip;
         we = we | res.mem_we;
      end
      r = res;
      if (k >= 20 || done !== 1'b1) begin
         n_mismatch++;
         end_of_test();
      end
   endtask

   // Return-with-literal doubles as the way to preload the accumulator
   task automatic ld(input logic [7:0] v);
      ex(MIE_OP_RETLIT, 1'b0, 8'h00, 8'h00, v);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_arith();
      ld(8'hF0);
      ex(MIE_OP_ADD, 1'b0, 8'h00, 8'h20, 8'h20);
      chk({r.acc, 7'h00, r.carry}, 16'h1001);
      ex(MIE_OP_ADC, 1'b0, 8'h00, 8'h05, 8'h05);
      chk({r.acc, 7'h00, r.carry}, 16'h1600);
      ld(8'h05);
      ex(MIE_OP_SUB, 1'b0, 8'h00, 8'h06, 8'h06);
      chk({r.acc, 7'h00, r.carry}, 16'hFF00);
      ex(MIE_OP_SBC, 1'b0, 8'h00, 8'h0E, 8'h0E);
      chk({r.acc, 7'h00, r.carry}, 16'hF001);
   endtask

   task automatic t_logic();
      mie_op_t ops[4] = '{MIE_OP_AND, MIE_OP_OR, MIE_OP_XOR, MIE_OP_COM};
      logic [7:0] mv[4] = '{8'h0F, 8'h0F, 8'h20, 8'hFF};
      logic [7:0] ea[4] = '{8'h00, 8'h2F, 8'h00, 8'h00};
      for (int n = 0; n < 4; n++) begin
         ld(8'hF8);
         ex(MIE_OP_ADD, 1'b0, 8'h00, 8'h28, 8'h28);
         ex(ops[n], 1'b0, 8'h00, mv[n], mv[n]);
         chk({r.acc, 5'h00, r.carry, r.dcarry, r.zero}, {ea[n], 7'h03, ea[n] == 8'h00});
      end
   endtask

   task automatic t_mem();
      logic [7:0] ad[4] = '{8'h7F, 8'h80, 8'h87, 8'h88};
      ld(8'h01);
      ex(MIE_OP_ADD, 1'b1, 8'h10, 8'h02, 8'h02);
      chk({r.mem_data, 3'h0, we, 2'h0, 2'(cyc)}, 16'h0312);
      ex(MIE_OP_ADD, 1'b1, 8'h85, 8'h02, 8'h02);
      chk({r.mem_data, 3'h0, we, 2'h0, 2'(cyc)}, 16'h0311);
      for (int n = 0; n < 4; n++) begin
         ex(MIE_OP_BZMOVI, 1'b1, ad[n], 8'h00, 8'h6C);
         chk(16'(we), 16'(n == 1 || n == 2));
         if (we === 1'b1) begin
            chk({r.mem_addr, r.mem_data}, {ad[n], 8'h6C});
         end
      end
   endtask

   task automatic t_muldaa();
      ld(8'h12);
      ex(MIE_OP_MUL, 1'b0, 8'h00, 8'h34, 8'h34);
      chk({r.acc, r.r}, 16'hA803);
      chk({r.zero, 2'(cyc)}, 3'h2);
      ld(8'h00);
      ex(MIE_OP_MUL, 1'b0, 8'h00, 8'h55, 8'h55);
      chk({r.r, 7'h00, r.zero}, 16'h0001);
      ld(8'h15);
      ex(MIE_OP_ADD, 1'b0, 8'h00, 8'h27, 8'h27);
      ex(MIE_OP_DAA, 1'b0, 8'h00, 8'h00, 8'h00);
      chk({r.acc, r.carry, 2'(cyc)}, 11'h211);
      ld(8'h99);
      ex(MIE_OP_ADD, 1'b0, 8'h00, 8'h01, 8'h01);
      ex(MIE_OP_DAA, 1'b0, 8'h00, 8'h00, 8'h00);
      chk({r.acc, r.carry, 2'(cyc)}, 11'h005);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_skip();
      ld(8'h40);
      ex(MIE_OP_CMPSKIP, 1'b0, 8'h00, 8'h40, 8'h40);
      chk({sk, r.zero, r.carry, 2'(cyc)}, 5'h1E);
      ex(MIE_OP_CMPSKIP, 1'b0, 8'h00, 8'h41, 8'h41);
      chk({sk, r.zero, r.carry, 2'(cyc)}, 5'h01);
      ex(MIE_OP_INCACC, 1'b0, 8'h10, 8'hFF, 8'h00);
      chk({r.acc, 3'h0, sk, 2'h0, 2'(cyc)}, 16'h0012);
      ex(MIE_OP_DECACC, 1'b0, 8'h10, 8'h05, 8'h00);
      chk({r.acc, 3'h0, sk, 2'h0, 2'(cyc)}, 16'h0401);
      ex(MIE_OP_INCMEM, 1'b1, 8'h10, 8'hFF, 8'h00);
      chk({r.mem_data, 4'h0, we, sk, 2'(cyc)}, 16'h000F);
      ex(MIE_OP_DECMEM, 1'b1, 8'h85, 8'h02, 8'h00);
      chk({r.mem_data, 4'h0, we, sk, 2'(cyc)}, 16'h0109);
      for (int n = 0; n < 8; n++) begin
         ex(MIE_OP_BITCLR, 1'b0, 8'h10, 8'hA5, 8'h00, 3'(n));
         chk(32'(sk), 32'(((8'hA5 >> n) & 1) == 0));
         chk(32'(cyc), 32'(1 + (((8'hA5 >> n) & 1) == 0)));
         ex(MIE_OP_BITSET, 1'b0, 8'h10, 8'hA5, 8'h00, 3'(n));
         chk(32'(sk), 32'(((8'hA5 >> n) & 1) == 1));
         chk(32'(cyc), 32'(1 + (((8'hA5 >> n) & 1) == 1)));
      end
   endtask

   task automatic t_flow();
      pg = 2'h2;
      ex(MIE_OP_JUMP, 1'b0, 8'h00, 8'h00, 8'h00, 3'h0, 14'h1234);
      chk(r.pc, 16'h9234);
      chk(16'(cyc), 16'h0002);
      p = r.pc;
      pg = 2'h1;
      ex(MIE_OP_CALL, 1'b0, 8'h00, 8'h00, 8'h00, 3'h0, 14'h0100);
      chk({r.pc, 2'(cyc)}, {16'h4100, 2'h2});
      ex(MIE_OP_RET, 1'b0, 8'h00, 8'h00, 8'h00);
      chk(r.pc, p + 16'h0001);
      rh = 8'hAB;
      rl = 8'hCD;
      ex(MIE_OP_CALL_VIA_HIGH_LOW_PAIR, 1'b0, 8'h00, 8'h00, 8'h00);
      chk({r.pc, 2'(cyc)}, {16'hABCD, 2'h2});
      ry = 8'h12;
      rz = 8'h34;
      ex(MIE_OP_CALLIDX, 1'b0, 8'h00, 8'h00, 8'h00);
      chk({r.pc, 2'(cyc)}, {16'h1234, 2'h2});
      ex(MIE_OP_IRET, 1'b0, 8'h00, 8'h00, 8'h00);
      chk({r.gie, 2'(cyc), r.pc}, {1'b1, 2'h2, 16'hABCE});
      ex(MIE_OP_RETLIT, 1'b0, 8'h00, 8'h00, 8'h5A);
      chk({r.acc, 2'(cyc)}, 10'h16A);
      chk(r.pc, p + 16'h0002);
   endtask

   initial begin
      rst = 1'b1;
      instr_valid = 1'b0;
      instr = '0;
      pg = 2'h0;
      rh = 8'h00;
      rl = 8'h00;
      ry = 8'h00;
      rz = 8'h00;
      n_mismatch = 0;
      compares = 0;
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      chk({res.pc, res.acc, 7'h00, instr_ready}, {MIE_PC_RST, 16'h0001});
      t_arith();
      t_logic();
      t_mem();
      t_muldaa();
      t_skip();
      t_flow();
      end_of_test();
   end
endmodule
